// ### design/rtc_cfg.svh
// timing and width constants for the record trigger control block
`ifndef RTC_CFG_SVH
`define RTC_CFG_SVH

`define RTC_CLK_MHZ     100
`define RTC_TC_W        32
`define RTC_HOLD_W      8
`define RTC_TC_LOSS_MS  100
`define RTC_TC_LOSS_CYC (`RTC_TC_LOSS_MS * `RTC_CLK_MHZ * 1000)
`define RTC_LOSS_CNT_W  24

`endif

// ### design/rtc_pkg.sv
// types shared by the record trigger control block
package rtc_pkg;

  typedef enum logic [1:0] {
    src_manual   = 2'b00,
    src_timecode = 2'b01,
    src_cam_flag = 2'b10
  } trig_src_t;

  typedef enum logic [1:0] {
    tc_internal             = 2'b00,
    tc_ext_ltc              = 2'b01,
    halt_on_missing_tc_mode = 2'b10,
    embedded_tc_source_mode = 2'b11
  } tc_mode_t;

  typedef enum logic [1:0] {
    xp_stop    = 2'b00,
    xp_capture = 2'b01,
    xp_rec     = 2'b10,
    xp_play    = 2'b11
  } xport_t;

endpackage : rtc_pkg

// ### design/gpio_in_cond.sv
// three-stage synchroniser, polarity and edge detect for one trigger pin
module gpio_in_cond
(
  input  wire logic clk,
  input  wire logic nrst,
  input  wire logic pin,
  input  wire logic active_low,
  output logic      asserted,
  output logic      pressed
);

  logic s1_r, s2_r, s3_r;
  logic lvl_r, lvl_nxt;
  logic prev_r, prev_nxt;

  // ----------------------------------------------------------------
  // sync and qualify
  // ----------------------------------------------------------------
  always_comb
  begin
    lvl_nxt  = (s2_r == s3_r) ? s3_r : lvl_r;
    prev_nxt = lvl_r;
  end

  // chain keeps sampling through reset: a pin held active across it is
  // settled at release and fires nothing
  // prev tracks the level, so a polarity flip alone issues no command
  always_ff @(posedge clk)
  begin
    s1_r   <= pin;
    s2_r   <= s1_r;
    s3_r   <= s2_r;
    lvl_r  <= lvl_nxt;
    prev_r <= nrst ? prev_nxt : lvl_nxt;
  end

  assign asserted = lvl_r ^ active_low;
  assign pressed  = asserted & (lvl_r ^ prev_r);

  chk_one_pulse: assert property (@(posedge clk) disable iff (!nrst)
    pressed |=> !pressed)
    else $error("trigger pulse lasted more than one cycle");

endmodule : gpio_in_cond

// ### design/record_trigger_control.sv
// transport trigger logic: timecode, camera flag and gpio sources
// ----------------------------------------------------------------
// ----------------------------------------------------------------
`include "rtc_cfg.svh"

module record_trigger_control
  import rtc_pkg::*;
#(
  parameter int TC_LOSS_CYC = `RTC_TC_LOSS_CYC,
  parameter int TC_W        = `RTC_TC_W,
  parameter int HOLD_W      = `RTC_HOLD_W
)
(
  input  wire logic              clk,
  input  wire logic              nrst,
  input  wire trig_src_t         trig_src,
  input  wire tc_mode_t          tc_mode,
  input  wire logic [HOLD_W-1:0] holdoff_frames,
  input  wire logic              in_active_low,
  input  wire logic              out_active_low,
  input  wire logic [2:0]        gpio_in_pins,
  input  wire logic              ltc_present_pin,
  input  wire logic [TC_W-1:0]   ext_tc_word,
  input  wire logic              ext_tc_strobe,
  input  wire logic [TC_W-1:0]   int_tc_word,
  input  wire logic              sdi_start_flag,
  input  wire logic              sdi_stop_flag,
  output logic [2:0]             gpio_out_pins,
  output logic [TC_W-1:0]        stamp_tc,
  output logic                   capturing,
  output logic                   recording,
  output logic                   capture_discard
);

  localparam int GP_REC  = 0;
  localparam int GP_PLAY = 1;
  localparam int GP_STOP = 2;
  localparam logic [`RTC_LOSS_CNT_W-1:0] LOSS_MAX = `RTC_LOSS_CNT_W'(TC_LOSS_CYC);

  // ----------------------------------------------------------------
  // input conditioning
  // ----------------------------------------------------------------
  logic [2:0] gp_press;
  logic       ltc_level;

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++)
    begin : g_in
      gpio_in_cond u_cond (
        .clk        (clk),
        .nrst       (nrst),
        .pin        (gpio_in_pins[gi]),
        .active_low (in_active_low),
        .asserted   (),
        .pressed    (gp_press[gi])
      );
    end
  endgenerate

  // ltc presence is a plain active-high detector level
  gpio_in_cond u_ltc (
    .clk        (clk),
    .nrst       (nrst),
    .pin        (ltc_present_pin),
    .active_low (1'b0),
    .asserted   (ltc_level),
    .pressed    ()
  );

  // ----------------------------------------------------------------
  // timecode motion tracking
  // ----------------------------------------------------------------
  logic [TC_W-1:0]              last_tc_r, last_tc_nxt;
  logic                         roll_r, roll_nxt;
  logic [`RTC_LOSS_CNT_W-1:0]   loss_cnt_r, loss_cnt_nxt;
  logic                         tc_changed, tc_live;
  logic                         roll_start, roll_end;

  function automatic logic is_flag_mode(input trig_src_t s, input tc_mode_t m);
    return (s == src_cam_flag) && (m == embedded_tc_source_mode);
  endfunction : is_flag_mode

  assign tc_changed = ext_tc_strobe && (ext_tc_word != last_tc_r);
  // a dead link sends no words at all, so silence also counts as stopped
  assign tc_live    = (loss_cnt_r < LOSS_MAX);
  assign roll_start = tc_changed && !roll_r;
  assign roll_end   = roll_r && ((ext_tc_strobe && !tc_changed) || !tc_live);

  always_comb
  begin
    last_tc_nxt  = ext_tc_strobe ? ext_tc_word : last_tc_r;
    roll_nxt     = roll_r;
    loss_cnt_nxt = loss_cnt_r;
    if (ext_tc_strobe)
    begin
      roll_nxt     = tc_changed;
      loss_cnt_nxt = '0;
    end
    else if (loss_cnt_r < LOSS_MAX)
    begin
      loss_cnt_nxt = loss_cnt_r + 1'b1;
    end
    if (!tc_live)
      roll_nxt = 1'b0;
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      last_tc_r  <= '0;
      roll_r     <= 1'b0;
      loss_cnt_r <= LOSS_MAX;
    end
    else
    begin
      last_tc_r  <= last_tc_nxt;
      roll_r     <= roll_nxt;
      loss_cnt_r <= loss_cnt_nxt;
    end
  end

  // ----------------------------------------------------------------
  // transport state machine
  // ----------------------------------------------------------------
  xport_t              state_r, state_nxt;
  logic [HOLD_W-1:0]   hold_cnt_r, hold_cnt_nxt;
  logic                discard_r, discard_nxt;
  logic                tc_mode_src, flag_ok, ltc_lost;

  assign tc_mode_src = (trig_src == src_timecode);
  assign flag_ok     = is_flag_mode(trig_src, tc_mode);
  assign ltc_lost    = (tc_mode == halt_on_missing_tc_mode) && !ltc_level;

  always_comb
  begin
    state_nxt    = state_r;
    hold_cnt_nxt = hold_cnt_r;
    discard_nxt  = 1'b0;
    unique case (state_r)
      xp_stop:
      begin
        if (gp_press[GP_STOP])
          state_nxt = xp_stop;
        else if (gp_press[GP_REC])
          state_nxt = xp_rec;
        else if (gp_press[GP_PLAY])
          state_nxt = xp_play;
        else if (flag_ok && sdi_start_flag)
          state_nxt = xp_rec;
        else if (tc_mode_src && roll_start && !ltc_lost)
        begin
          // capture starts the moment code rolls, or record does at once with zero hold-off; commit waits out hold-off
          hold_cnt_nxt = holdoff_frames;
          state_nxt    = (holdoff_frames == '0) ? xp_rec : xp_capture;
        end
      end
      xp_capture:
      begin
        if (gp_press[GP_REC] && !gp_press[GP_STOP])
          state_nxt = xp_rec;
        else if (gp_press[GP_STOP] || ltc_lost || !tc_live ||
            (ext_tc_strobe && !tc_changed))
        begin
          state_nxt   = xp_stop;
          discard_nxt = 1'b1;
        end
        else if (tc_changed)
        begin
          if (hold_cnt_r == HOLD_W'(1))
            state_nxt = xp_rec;
          else
            hold_cnt_nxt = hold_cnt_r - 1'b1;
        end
      end
      xp_rec:
      begin
        if (gp_press[GP_STOP])
          state_nxt = xp_stop;
        else if (gp_press[GP_REC])
          state_nxt = xp_rec;
        else if (ltc_lost)
          state_nxt = xp_stop;
        else if (flag_ok && sdi_stop_flag)
          state_nxt = xp_stop;
        else if (tc_mode_src && roll_end)
          state_nxt = xp_stop;
      end
      xp_play:
      begin
        if (gp_press[GP_STOP])
          state_nxt = xp_stop;
        else if (gp_press[GP_REC])
          state_nxt = xp_rec;
      end
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      state_r    <= xp_stop;
      hold_cnt_r <= '0;
      discard_r  <= 1'b0;
    end
    else
    begin
      state_r    <= state_nxt;
      hold_cnt_r <= hold_cnt_nxt;
      discard_r  <= discard_nxt;
    end
  end

  assign capture_discard = discard_r;

  // ----------------------------------------------------------------
  // indicator outputs and timecode stamp
  // ----------------------------------------------------------------
  logic [2:0]      out_r, out_nxt;
  logic [TC_W-1:0] stamp_r, stamp_nxt;
  logic            cap_r, rec_r;

  always_comb
  begin
    // capture is not yet a committed take, so it shows as stopped
    out_nxt[GP_REC]  = (state_r == xp_rec)  ^ out_active_low;
    out_nxt[GP_PLAY] = (state_r == xp_play) ^ out_active_low;
    out_nxt[GP_STOP] = ((state_r == xp_stop) || (state_r == xp_capture))
                       ^ out_active_low;
    // trigger source plays no part here on purpose
    stamp_nxt = (tc_mode == tc_internal) ? int_tc_word : ext_tc_word;
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      out_r   <= '0;
      stamp_r <= '0;
      cap_r   <= 1'b0;
      rec_r   <= 1'b0;
    end
    else
    begin
      out_r   <= out_nxt;
      stamp_r <= stamp_nxt;
      cap_r   <= (state_nxt == xp_capture);
      rec_r   <= (state_nxt == xp_rec);
    end
  end

  assign gpio_out_pins = out_r;
  assign stamp_tc      = stamp_r;
  assign capturing     = cap_r;
  assign recording     = rec_r;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence s_tc_roll_from_stop;
    tc_mode_src && roll_start && (state_r == xp_stop) && !ltc_lost && (gp_press == 3'b000);
  endsequence

  chk_stop_press: assert property (@(posedge clk) disable iff (!nrst)
    gp_press[GP_STOP] |=> (state_r == xp_stop))
    else $error("stop press did not stop the transport");

  chk_rec_press: assert property (@(posedge clk) disable iff (!nrst)
    gp_press[GP_REC] && !gp_press[GP_STOP] |=> recording && (state_r == xp_rec))
    else $error("record press did not start recording");

  chk_play_press: assert property (@(posedge clk) disable iff (!nrst)
    (state_r == xp_stop) && gp_press == 3'b010 |=> (state_r == xp_play))
    else $error("play press from stop did not start playback");

  chk_flag_gate: assert property (@(posedge clk) disable iff (!nrst)
    (state_r == xp_stop) && !flag_ok && !tc_mode_src && gp_press == 3'b000
      |=> (state_r == xp_stop))
    else $error("transport left stop with camera flags gated off");

  chk_halt_ltc: assert property (@(posedge clk) disable iff (!nrst)
    (state_r == xp_rec) && ltc_lost && !gp_press[GP_REC] |=> (state_r == xp_stop))
    else $error("recording continued after linear timecode loss");

  chk_holdoff_path: assert property (@(posedge clk) disable iff (!nrst)
    s_tc_roll_from_stop |=> ($past(holdoff_frames) == '0) ? (state_r == xp_rec)
                                                        : (state_r == xp_capture))
    else $error("rolling timecode did not start capture or record");

  chk_out_pins: assert property (@(posedge clk) disable iff (!nrst)
    ##1 gpio_out_pins[GP_REC] == (($past(state_r) == xp_rec) ^ $past(out_active_low)))
    else $error("record output does not follow transport state");

  chk_stamp_src: assert property (@(posedge clk) disable iff (!nrst)
    (tc_mode == tc_internal) |=> stamp_tc == $past(int_tc_word))
    else $error("stamp does not come from internal timecode");

  chk_stamp_ext: assert property (@(posedge clk) disable iff (!nrst)
    (tc_mode != tc_internal) |=> stamp_tc == $past(ext_tc_word))
    else $error("stamp does not come from external timecode");

  chk_tc_stop: assert property (@(posedge clk) disable iff (!nrst)
    (state_r == xp_rec) && tc_mode_src && roll_end && gp_press == 3'b000
      |=> (state_r == xp_stop) ##1 gpio_out_pins[GP_STOP] != out_active_low)
    else $error("stationary timecode did not stop recording");

endmodule : record_trigger_control

// ### sim/tc_master_model.sv
// timecode master and linear timecode presence model for the trigger bench
module tc_master_model
(
  input  wire logic        clk,
  input  wire logic        send,
  input  wire logic        run,
  input  wire logic        ltc_on,
  output logic [31:0]      ext_tc_word,
  output logic             ext_tc_strobe,
  output logic             ltc_present_pin
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [31:0] word_r;
  logic [1:0]  slot_r;

  initial
  begin
    word_r          = 32'h0100_0000;
    slot_r          = 2'h0;
    ext_tc_word     = 32'hfeff_ffff;
    ext_tc_strobe   = 1'b0;
    ltc_present_pin = 1'b1;
  end

  // ----------------------------------------------------------------
  // one frame every four clocks while sending
  // ----------------------------------------------------------------
  always @(posedge clk)
  begin
    slot_r          <= slot_r + 2'h1;
    ltc_present_pin <= ltc_on;
    if (send && slot_r == 2'h3)
    begin
      // stationary code while stopped, rolling code while recording
      word_r        <= run ? word_r + 32'h1 : word_r;
      ext_tc_word   <= run ? word_r + 32'h1 : word_r;
      ext_tc_strobe <= 1'b1;
    end
    else
    begin
      // word is only valid with the strobe, so show garbage between frames
      ext_tc_word   <= ~word_r;
      ext_tc_strobe <= 1'b0;
    end
  end
endmodule : tc_master_model

// ### sim/record_trigger_control_bench.sv
// self-checking bench for the record trigger control block
module record_trigger_control_bench;
  import rtc_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk = 1'b0;
  logic nrst = 1'b0;
  trig_src_t trig_src = src_manual;
  tc_mode_t tc_mode = tc_internal;
  logic [7:0] holdoff = 8'h00;
  logic in_lo = 1'b0;
  logic out_lo = 1'b0;
  logic [2:0] pin_act = 3'h0;
  logic [31:0] int_tc = 32'h0;
  logic sdi_start = 1'b0;
  logic sdi_stop = 1'b0;
  logic send = 1'b0;
  logic run = 1'b0;
  logic ltc_on = 1'b1;
  logic rec_prev = 1'b0;
  logic [31:0] ext_word;
  logic ext_stb, ltc_pin, capturing, recording, discard;
  logic [2:0] gpio_out_pins;
  logic [31:0] stamp_tc;
  wire logic [2:0] gpio_in_pins = pin_act ^ {3{in_lo}};
  logic exp_q[$];
  int num_errors = 0;
  int check_count = 0;

  always #5 clk = ~clk;

  record_trigger_control #(.TC_LOSS_CYC(50)) record_trigger_control_i (
    .clk(clk), .nrst(nrst), .trig_src(trig_src), .tc_mode(tc_mode),
    .holdoff_frames(holdoff), .in_active_low(in_lo), .out_active_low(out_lo),
    .gpio_in_pins(gpio_in_pins), .ltc_present_pin(ltc_pin), .ext_tc_word(ext_word),
    .ext_tc_strobe(ext_stb), .int_tc_word(int_tc), .sdi_start_flag(sdi_start),
    .sdi_stop_flag(sdi_stop), .gpio_out_pins(gpio_out_pins), .stamp_tc(stamp_tc),
    .capturing(capturing), .recording(recording), .capture_discard(discard));

  tc_master_model tc_master_model_i (
    .clk(clk), .send(send), .run(run), .ltc_on(ltc_on), .ext_tc_word(ext_word),
    .ext_tc_strobe(ext_stb), .ltc_present_pin(ltc_pin));

  // ----------------------------------------------------------------
  // checking and waiting
  // ----------------------------------------------------------------
  task automatic test_done();
    $display("errors %0d checks %0d", num_errors, check_count);
    if (num_errors == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : test_done

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc

  // sel 0 recording, 1 capturing, 2 discard pulse
  task automatic wait_out(input int sel, input logic v);
    int n;
    for (n = 0; n < 40; n++)
    begin
      @(posedge clk);
      if ((sel == 0 ? recording : sel == 1 ? capturing : discard) === v)
        break;
    end
    if (n == 40)
    begin
      num_errors++;
      $display("[FAIL] %0t wait on output %0d ran out", $time, sel);
      test_done();
    end
  endtask : wait_out

  task automatic expect_rec(input logic v);
    exp_q.push_back(v);
    wait_out(0, v);
  endtask : expect_rec

  task automatic press(input int i);
    pin_act[i] <= 1'b1;
    cyc(4);
    pin_act[i] <= 1'b0;
    cyc(8);
  endtask : press

  task automatic flag(input logic start);
    if (start)
      sdi_start <= 1'b1;
    else
      sdi_stop <= 1'b1;
    @(posedge clk);
    sdi_start <= 1'b0;
    sdi_stop  <= 1'b0;
  endtask : flag

  function automatic logic [2:0] outv(input logic [2:0] s);
    return out_lo ? ~s : s;
  endfunction : outv

  // every change of recording must match the oldest note
  always @(posedge clk)
  begin
    if (nrst && recording !== rec_prev)
      if (exp_q.size() == 0)
        check(32'(recording), 32'(rec_prev));
      else
        check(32'(recording), 32'(exp_q.pop_front()));
    rec_prev <= recording;
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    void'($urandom(32'h6fbd));
    cyc(12);
    nrst <= 1'b1;
    cyc(4);
    // polarity passes: {out, in}
    for (int p = 0; p < 3; p++)
    begin
      in_lo  <= p[0];
      out_lo <= p[1];
      cyc(6);
      pin_act[0] <= 1'b1;
      expect_rec(1'b1);
      cyc(2);
      check(32'(gpio_out_pins), 32'(outv(3'b001)));
      exp_q.push_back(1'b0);
      press(2);
      wait_out(0, 1'b0);
      cyc(20);
      pin_act[0] <= 1'b0;
      cyc(2);
      press(1);
      check(32'(gpio_out_pins), 32'(outv(3'b010)));
      press(2);
      check(32'(gpio_out_pins), 32'(outv(3'b100)));
    end
    trig_src <= src_timecode;
    run      <= 1'b1;
    send     <= 1'b1;
    expect_rec(1'b1);
    for (int k = 0; k < 4; k++)
    begin
      int_tc <= $urandom;
      cyc(3);
      check(stamp_tc, int_tc);
    end
    run <= 1'b0;
    expect_rec(1'b0);
    holdoff <= 8'h03;
    run     <= 1'b1;
    wait_out(1, 1'b1);
    run <= 1'b0;
    wait_out(2, 1'b1);
    holdoff <= 8'h02;
    run     <= 1'b1;
    wait_out(1, 1'b1);
    expect_rec(1'b1);
    check(32'(capturing), 32'h0);
    run <= 1'b0;
    expect_rec(1'b0);
    holdoff <= 8'h00;
    tc_mode <= halt_on_missing_tc_mode;
    run     <= 1'b1;
    expect_rec(1'b1);
    ltc_on <= 1'b0;
    expect_rec(1'b0);
    cyc(20);
    send   <= 1'b0;
    ltc_on <= 1'b1;
    trig_src <= src_cam_flag;
    tc_mode  <= embedded_tc_source_mode;
    cyc(60);
    flag(1'b1);
    expect_rec(1'b1);
    flag(1'b0);
    expect_rec(1'b0);
    tc_mode <= tc_ext_ltc;
    cyc(2);
    flag(1'b1);
    cyc(10);
    check(32'(recording), 32'h0);
    check(32'(exp_q.size()), 32'h0);
    test_done();
  end
endmodule : record_trigger_control_bench
